// ==== hw/fswl_top.sv ====
`timescale 1ns/1ns
module fswl_top #(
  parameter logic [7:0] RD_STATUS_OP  = 8'h05,
  parameter logic [7:0] WR_DISABLE_OP = 8'h04,
  parameter logic [7:0] VOL_UNLOCK_OP = 8'h50,
  parameter logic [7:0] SOFT_RST_OP   = 8'h99,
  parameter int         OP_CYCLES     = 200
) (
  input  wire logic                        i_clk,
  input  wire logic                        i_nrst,
  input  wire logic                        i_factory_nrst,
  input  wire logic                        i_sck,
  input  wire logic                        i_cs_n,
  input  wire logic                        i_si,
  input  wire logic                        i_wp_n,
  input  wire logic                        i_hold_rst_n,
  output logic                             o_so,
  output logic                             o_so_oe_n,
  output logic [fswl_pkg::SR_W-1:0]        o_status,
  output logic                             o_busy,
  output logic                             o_quad_en,
  output logic                             o_refused
);
  import fswl_pkg::*;

  // ------------------------------------------------------------
  // Pin sampling
  // ------------------------------------------------------------
  logic [4:0] pins_s;

  fswl_sync #(.W(5), .RST(PIN_RESET)) u_sync (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .i_d    ({i_sck, i_cs_n, i_si, i_wp_n, i_hold_rst_n}),
    .o_q    (pins_s)
  );

  wire sck_s  = pins_s[4];
  wire csn_s  = pins_s[3];
  wire si_s   = pins_s[2];
  wire wpn_s  = pins_s[1];
  wire hrst_s = pins_s[0];

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic             sck_d_ff;
  logic             csn_d_ff;
  logic [7:0]       shreg_ff;
  logic [2:0]       bitcnt_ff;
  logic [2:0]       bytecnt_ff;
  logic [7:0]       opcode_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [7:0]       data_ff;
  logic             frame_ok_ff;
  logic [7:0]       out_sh_ff;
  logic             so_ff;
  logic             so_oe_n_ff;
  logic [VOL_W-1:0] vol_ff;
  logic             wel_ff;
  logic             busy_ff;
  logic             susp_ff;
  logic             op_status_write_cmd_ff;
  logic [15:0]      op_cnt_ff;
  logic             unlock_ff;
  logic             refused_ff;
  logic [SR_W-1:0]  status_ff;
  fswl_pu_t         pu_st_ff;
  logic [VOL_W-1:0] nv_q;

  localparam logic [15:0] OP_CNT = 16'(OP_CYCLES);

  // ------------------------------------------------------------
  // Frame decode
  // ------------------------------------------------------------
  wire       sck_rise   = ~csn_s & sck_s & ~sck_d_ff;
  wire       sck_fall   = ~csn_s & ~sck_s & sck_d_ff;
  wire       cs_rise    = csn_s & ~csn_d_ff;
  wire       cs_fall    = ~csn_s & csn_d_ff;
  wire       byte_done  = sck_rise & (bitcnt_ff == 3'h7);
  wire [7:0] in_byte    = {shreg_ff[6:0], si_s};
  wire [2:0] nxt_bytecnt = (byte_done && bytecnt_ff != LEN_SAT) ? bytecnt_ff + 3'h1 : bytecnt_ff;
  wire       ready      = (pu_st_ff == PU_RUN);
  wire       exec       = cs_rise & frame_ok_ff & (bitcnt_ff == 3'h0);
  wire       idle       = ~busy_ff & ready;

  wire c_write_enable_cmd   = (opcode_ff == OP_WRITE_ENABLE_CMD) && (bytecnt_ff == LEN_CMD);
  wire c_write_disable_cmd   = (opcode_ff == WR_DISABLE_OP) && (bytecnt_ff == LEN_CMD);
  wire c_unlock = (opcode_ff == VOL_UNLOCK_OP) && (bytecnt_ff == LEN_CMD);
  wire c_status_write_cmd   = (opcode_ff == OP_STATUS_WRITE_CMD) && (bytecnt_ff == LEN_STATUS_WRITE_CMD);
  wire c_prog   = (opcode_ff == OP_PROG) && (bytecnt_ff >= LEN_PROG);
  wire c_sect   = ((opcode_ff == OP_SER_A) || (opcode_ff == OP_SER_B) || (opcode_ff == OP_BER32)
                  || (opcode_ff == OP_BER64)) && (bytecnt_ff == LEN_ERASE);
  wire c_chip   = ((opcode_ff == OP_CHIP_A) || (opcode_ff == OP_CHIP_B)) && (bytecnt_ff == LEN_CMD);
  wire c_susp   = (opcode_ff == OP_SUSPEND) && (bytecnt_ff == LEN_CMD);
  wire c_resume = (opcode_ff == OP_RESUME) && (bytecnt_ff == LEN_CMD);
  wire c_srst   = (opcode_ff == SOFT_RST_OP) && (bytecnt_ff == LEN_CMD);

  // ------------------------------------------------------------
  // Protection and gating
  // ------------------------------------------------------------
  wire       quad_en   = vol_ff[VOL_QUAD];
  wire       wp_low    = ~quad_en & ~wpn_s;
  wire       hw_rst    = ~quad_en & ~hrst_s;
  wire       sr_locked = vol_ff[VOL_LOCK] & wp_low;
  wire [3:0] prot      = vol_ff[VOL_PROT_MSB:0];
  wire [8:0] prot_n    = (prot == 4'h0) ? 9'h000 :
                         (prot >= PROT_ALL_LVL) ? PROT_BLOCKS : (9'h001 << (prot - 4'h1));
  wire [8:0] prot_base = PROT_BLOCKS - prot_n;
  wire       prot_hit  = (prot != 4'h0) && ({1'b0, addr_ff[ADDR_W-1 -: 8]} >= prot_base);
  wire       chip_ok   = (prot == 4'h0);

  // Write-class work needs an idle device and the write latch set, except a status write after the volatile unlock
  wire go_status_write_cmd_nv  = exec & idle & c_status_write_cmd & ~unlock_ff & wel_ff & ~sr_locked;
  wire go_status_write_cmd_vol = exec & idle & c_status_write_cmd & unlock_ff & ~sr_locked;
  wire go_pe       = exec & idle & wel_ff & ~susp_ff &
                     (((c_prog | c_sect) & ~prot_hit) | (c_chip & chip_ok));
  wire start_op    = go_status_write_cmd_nv | go_pe;
  wire refuse      = exec & (c_status_write_cmd | c_prog | c_sect | c_chip) & ~start_op & ~go_status_write_cmd_vol;
  wire op_done     = busy_ff & (op_cnt_ff == 16'h0001);
  wire go_susp     = exec & c_susp & busy_ff & ~op_status_write_cmd_ff;
  wire go_resume   = exec & c_resume & susp_ff & ~busy_ff;
  wire go_reset    = (exec & c_srst) | hw_rst;
  wire set_wel     = exec & idle & c_write_enable_cmd;
  wire clr_wel     = exec & idle & c_write_disable_cmd;
  wire rd_now      = byte_done & frame_ok_ff &
                     (((bytecnt_ff == 3'h0) && (in_byte == RD_STATUS_OP)) ||
                      ((bytecnt_ff != 3'h0) && (opcode_ff == RD_STATUS_OP)));
  wire [SR_W-1:0] status = {vol_ff, wel_ff, busy_ff};

  // ------------------------------------------------------------
  // Serial framing
  // ------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      sck_d_ff    <= PIN_RESET[4];
      csn_d_ff    <= PIN_RESET[3];
      shreg_ff    <= 8'h00;
      bitcnt_ff   <= 3'h0;
      bytecnt_ff  <= 3'h0;
      opcode_ff   <= OP_NONE;
      addr_ff     <= '0;
      data_ff     <= 8'h00;
      frame_ok_ff <= 1'b0;
    end else begin
      sck_d_ff <= sck_s;
      csn_d_ff <= csn_s;
      if (cs_fall) begin
        bitcnt_ff   <= 3'h0;
        bytecnt_ff  <= 3'h0;
        opcode_ff   <= OP_NONE;
        frame_ok_ff <= ready;
      end else if (sck_rise) begin
        shreg_ff   <= in_byte;
        bitcnt_ff  <= bitcnt_ff + 3'h1;
        bytecnt_ff <= nxt_bytecnt;
        if (byte_done && bytecnt_ff == 3'h0) begin
          opcode_ff <= in_byte;
        end
        if (byte_done && bytecnt_ff == 3'h1) begin
          data_ff <= in_byte;
        end
        if (byte_done && bytecnt_ff != 3'h0 && bytecnt_ff < LEN_ERASE) begin
          addr_ff <= {addr_ff[ADDR_W-9:0], in_byte};
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Status read-out
  // ------------------------------------------------------------
  // Reloaded at every byte boundary, so a long read keeps repeating the byte
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      out_sh_ff  <= 8'h00;
      so_ff      <= 1'b0;
      so_oe_n_ff <= 1'b1;
    end else begin
      if (rd_now) begin
        out_sh_ff <= status;
      end else if (sck_fall) begin
        out_sh_ff <= {out_sh_ff[6:0], 1'b0};
      end
      if (sck_fall) begin
        so_ff <= out_sh_ff[7];
      end
      if (csn_s) begin
        so_oe_n_ff <= 1'b1;
      end else if (rd_now) begin
        so_oe_n_ff <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Internal operation timer
  // ------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_nrst || go_reset) begin
      busy_ff    <= 1'b0;
      susp_ff    <= 1'b0;
      op_status_write_cmd_ff <= 1'b0;
      op_cnt_ff  <= 16'h0000;
    end else if (start_op) begin
      busy_ff    <= 1'b1;
      op_status_write_cmd_ff <= go_status_write_cmd_nv;
      op_cnt_ff  <= OP_CNT;
    end else if (go_susp) begin
      busy_ff <= 1'b0;
      susp_ff <= 1'b1;
    end else if (go_resume) begin
      busy_ff <= 1'b1;
      susp_ff <= 1'b0;
    end else if (busy_ff) begin
      op_cnt_ff <= op_cnt_ff - 16'h0001;
      if (op_done) begin
        busy_ff <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Write latch and volatile unlock
  // ------------------------------------------------------------
  // Status writes touch the latch only when a nonvolatile one completes; completion wins over a new enable
  always_ff @(posedge i_clk) begin
    if (!i_nrst || go_reset) begin
      wel_ff    <= 1'b0;
      unlock_ff <= 1'b0;
    end else begin
      if (op_done) begin
        wel_ff <= 1'b0;
      end else if (set_wel) begin
        wel_ff <= 1'b1;
      end else if (clr_wel) begin
        wel_ff <= 1'b0;
      end
      if (exec && idle) begin
        unlock_ff <= c_unlock;
      end
    end
  end

  // ------------------------------------------------------------
  // Volatile copy and power-up load
  // ------------------------------------------------------------
  fswl_nvreg #(.W(VOL_W)) u_nv (
    .i_clk          (i_clk),
    .i_factory_nrst (i_factory_nrst),
    .i_we           (go_status_write_cmd_nv),
    .i_wd           (data_ff[SR_W-1:PROT_LSB]),
    .o_rd           (nv_q)
  );

  always_ff @(posedge i_clk) begin
    if (!i_nrst || go_reset) begin
      pu_st_ff <= PU_WAIT;
      vol_ff   <= SR_RESET[SR_W-1:PROT_LSB];
    end else begin
      case (pu_st_ff)
        PU_WAIT: begin
          pu_st_ff <= PU_LOAD;
        end
        PU_LOAD: begin
          vol_ff   <= nv_q;
          pu_st_ff <= PU_RUN;
        end
        PU_RUN: begin
          if (go_status_write_cmd_nv || go_status_write_cmd_vol) begin
            vol_ff <= data_ff[SR_W-1:PROT_LSB];
          end
        end
        default: begin
          pu_st_ff <= PU_WAIT;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      status_ff  <= SR_RESET;
      refused_ff <= 1'b0;
    end else begin
      status_ff  <= status;
      refused_ff <= refuse;
    end
  end

  assign o_so      = so_ff;
  assign o_so_oe_n = so_oe_n_ff;
  assign o_status  = status_ff;
  assign o_busy    = busy_ff;
  assign o_quad_en = vol_ff[VOL_QUAD];
  assign o_refused = refused_ff;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  read_repeat_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    rd_now |=> (out_sh_ff == $past(status)) && !so_oe_n_ff)
    else $error("status byte not reloaded");
  powerup_gate_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !ready |-> !start_op && !set_wel)
    else $error("instruction taken before load");
  write_enable_cmd_sets_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    set_wel && !op_done && !go_reset |=> wel_ff ##1 wel_ff || $past(exec))
    else $error("write enable lost");
  write_disable_cmd_clears_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    clr_wel |=> !wel_ff)
    else $error("write disable ignored");
  status_write_cmd_keeps_latch_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    exec && c_status_write_cmd && !op_done && !go_reset |=> wel_ff == $past(wel_ff))
    else $error("status write changed latch");
  op_busy_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    start_op && !go_reset |=> busy_ff [*2])
    else $error("busy not held");
  done_clear_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    op_done |=> !busy_ff && !wel_ff)
    else $error("completion did not clear flags");
  no_latch_block_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    exec && !wel_ff && !busy_ff && (c_prog || c_sect || c_chip) |=> !busy_ff)
    else $error("write ran without latch");
  chip_prot_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    exec && c_chip && !chip_ok && !busy_ff && !go_reset |=> !busy_ff && $stable(wel_ff))
    else $error("chip erase under protection");
  busy_filter_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    busy_ff && exec && (c_write_enable_cmd || c_write_disable_cmd) && !op_done |=> wel_ff == $past(wel_ff))
    else $error("latch changed while busy");
  lock_hold_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    exec && c_status_write_cmd && sr_locked |=> $stable(vol_ff) && !$rose(busy_ff))
    else $error("locked status written");
  suspend_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    go_susp && !go_reset |=> susp_ff && !busy_ff)
    else $error("suspend refused");
endmodule

// ==== hw/fswl_pkg.sv ====
package fswl_pkg;
  // ------------------------------------------------------------
  // Status byte layout
  // ------------------------------------------------------------
  localparam int          SR_W         = 8;
  localparam int          VOL_W        = 6;
  localparam int          BUSY_POS     = 0;
  localparam int          WLATCH_POS   = 1;
  localparam int          PROT_LSB     = 2;
  localparam int          PROT_MSB     = 5;
  localparam int          QUAD_POS     = 6;
  localparam int          LOCK_POS     = 7;
  localparam int          VOL_PROT_MSB = PROT_MSB - PROT_LSB;
  localparam int          VOL_QUAD     = QUAD_POS - PROT_LSB;
  localparam int          VOL_LOCK     = LOCK_POS - PROT_LSB;
  localparam logic [7:0]  SR_RESET     = 8'h00;
  localparam logic [5:0]  NV_RESET     = 6'h00;

  // ------------------------------------------------------------
  // Instruction codes
  // ------------------------------------------------------------
  localparam logic [7:0]  OP_NONE      = 8'h00;
  localparam logic [7:0]  OP_WRITE_ENABLE_CMD      = 8'h06;
  localparam logic [7:0]  OP_STATUS_WRITE_CMD      = 8'h01;
  localparam logic [7:0]  OP_PROG      = 8'h02;
  localparam logic [7:0]  OP_SER_A     = 8'hd7;
  localparam logic [7:0]  OP_SER_B     = 8'h20;
  localparam logic [7:0]  OP_BER32     = 8'h52;
  localparam logic [7:0]  OP_BER64     = 8'hd8;
  localparam logic [7:0]  OP_CHIP_A    = 8'hc7;
  localparam logic [7:0]  OP_CHIP_B    = 8'h60;
  localparam logic [7:0]  OP_SUSPEND   = 8'h75;
  localparam logic [7:0]  OP_RESUME    = 8'h7a;

  // ------------------------------------------------------------
  // Frame lengths in bytes, addressing, protection
  // ------------------------------------------------------------
  localparam logic [2:0]  LEN_CMD      = 3'h1;
  localparam logic [2:0]  LEN_STATUS_WRITE_CMD     = 3'h2;
  localparam logic [2:0]  LEN_ERASE    = 3'h4;
  localparam logic [2:0]  LEN_PROG     = 3'h5;
  localparam logic [2:0]  LEN_SAT      = 3'h7;
  localparam int          ADDR_W       = 24;
  localparam logic [8:0]  PROT_BLOCKS  = 9'h100;
  localparam logic [3:0]  PROT_ALL_LVL = 4'h9;
  localparam logic [4:0]  PIN_RESET    = 5'h1f;

  typedef enum logic [1:0] {PU_WAIT, PU_LOAD, PU_RUN} fswl_pu_t;
endpackage

// ==== hw/fswl_sync.sv ====
`timescale 1ns/1ns
module fswl_sync #(
  parameter int         W   = 5,
  parameter logic [4:0] RST = 5'h1f
) (
  input  wire logic         i_clk,
  input  wire logic         i_nrst,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  // Only the second stage is visible to any logic
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      meta_ff <= RST[W-1:0];
      q_ff    <= RST[W-1:0];
    end else begin
      meta_ff <= i_d;
      q_ff    <= meta_ff;
    end
  end

  assign o_q = q_ff;
endmodule

// ==== hw/fswl_nvreg.sv ====
`timescale 1ns/1ns
module fswl_nvreg #(
  parameter int W = 6
) (
  input  wire logic         i_clk,
  input  wire logic         i_factory_nrst,
  input  wire logic         i_we,
  input  wire logic [W-1:0] i_wd,
  output logic      [W-1:0] o_rd
);
  import fswl_pkg::*;

  logic [W-1:0] cell_ff;
  logic [W-1:0] rd_ff;

  // Cells survive the power-up reset; only the factory clear resets them
  always_ff @(posedge i_clk) begin
    if (!i_factory_nrst) begin
      cell_ff <= NV_RESET[W-1:0];
      rd_ff   <= NV_RESET[W-1:0];
    end else begin
      if (i_we) begin
        cell_ff <= i_wd;
      end
      rd_ff <= cell_ff;
    end
  end

  assign o_rd = rd_ff;
endmodule

// ==== testbench/fswl_host.sv ====
`timescale 1ns/1ns
module fswl_host (
  input  wire logic i_clk,
  input  wire logic i_so,
  output logic      o_sck,
  output logic      o_cs_n,
  output logic      o_si
);
  typedef logic [7:0] fswl_bq_t[$];
  fswl_bq_t rx_q;
  initial begin
    o_sck  = 1'b0;
    o_cs_n = 1'b1;
    o_si   = 1'b0;
  end
  // ------------------------------------------------------------
  // One frame, mode 0, 8 clk per bit
  // ------------------------------------------------------------
  // Clock stands still low between frames; data flips when deselected
  task automatic xfer(input fswl_bq_t tx);
    logic [7:0] rx;
    rx_q = {};
    @(posedge i_clk) o_cs_n <= 1'b0;
    repeat (3) @(posedge i_clk);
    foreach (tx[k]) begin
      for (int b = 7; b >= 0; b--) begin
        @(posedge i_clk) o_sck <= 1'b0;
        o_si <= tx[k][b];
        repeat (3) @(posedge i_clk);
        @(posedge i_clk) o_sck <= 1'b1;
        rx = {rx[6:0], i_so};
        repeat (3) @(posedge i_clk);
      end
      rx_q.push_back(rx);
    end
    @(posedge i_clk) o_sck <= 1'b0;
    repeat (2) @(posedge i_clk);
    o_cs_n <= 1'b1;
    o_si   <= ~o_si;
    repeat (6) @(posedge i_clk);
  endtask
endmodule

// ==== testbench/tb.sv ====
`timescale 1ns/1ns
module tb;
  import fswl_pkg::*;
  logic       i_clk          = 1'b0;
  logic       i_nrst         = 1'b0;
  logic       i_factory_nrst = 1'b0;
  logic       i_wp_n         = 1'b1;
  logic       i_hold_rst_n   = 1'b1;
  logic       sck, cs_n, si, so, so_oe_n, busy, quad_en, refused;
  logic [7:0] status;
  logic [7:0] n_ref          = 8'h00;
  logic [7:0] d;
  int         n_mismatch     = 0;
  int         cmp_count      = 0;
  int         seed;

  always #20 i_clk = ~i_clk;
  always @(posedge i_clk) if (refused === 1'b1) n_ref <= n_ref + 8'h01;

  // Long enough that a status read fits inside one operation
  fswl_top #(.OP_CYCLES(400)) i_fswl_top (
    .i_clk          (i_clk),
    .i_nrst         (i_nrst),
    .i_factory_nrst (i_factory_nrst),
    .i_sck          (sck),
    .i_cs_n         (cs_n),
    .i_si           (si),
    .i_wp_n         (i_wp_n),
    .i_hold_rst_n   (i_hold_rst_n),
    .o_so           (so),
    .o_so_oe_n      (so_oe_n),
    .o_status       (status),
    .o_busy         (busy),
    .o_quad_en      (quad_en),
    .o_refused      (refused)
  );
  fswl_host i_fswl_host (
    .i_clk  (i_clk),
    .i_so   (so),
    .o_sck  (sck),
    .o_cs_n (cs_n),
    .o_si   (si)
  );

  // ------------------------------------------------------------
  // Checking helpers
  // ------------------------------------------------------------
  task automatic give_verdict;
    if (n_mismatch == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask
  function automatic logic [7:0] exp_sr(logic [7:0] dd, logic wl, logic bz);
    return {dd[7:2], wl, bz};
  endfunction
  // Two repeated bytes after the opcode, plus the parallel copy
  task automatic sr_chk(input logic [7:0] e);
    i_fswl_host.xfer('{i_fswl_top.RD_STATUS_OP, 8'h00, 8'h00});
    chk("status byte 1", e, i_fswl_host.rx_q[1]);
    chk("status byte 2", e, i_fswl_host.rx_q[2]);
    chk("status port", e, status);
    // Output driver must be released once the host deselects
    chk("so enable", 8'h01, {7'h00, so_oe_n});
  endtask
  task automatic wait_idle;
    int k;
    for (k = 0; k < 1000 && busy !== 1'b0; k++) @(posedge i_clk);
    if (k == 1000) begin
      n_mismatch++;
      give_verdict;
    end
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    seed = 91;
    repeat (16) @(posedge i_clk);
    i_nrst         <= 1'b1;
    i_factory_nrst <= 1'b1;
    repeat (8) @(posedge i_clk);
    sr_chk(8'h00);
    i_fswl_host.xfer('{OP_STATUS_WRITE_CMD, 8'hfc});
    chk("refused count", 8'h01, n_ref);
    sr_chk(8'h00);
    i_fswl_host.xfer('{OP_WRITE_ENABLE_CMD});
    sr_chk(8'h02);
    i_fswl_host.xfer('{i_fswl_top.VOL_UNLOCK_OP});
    sr_chk(8'h02);
    i_fswl_host.xfer('{i_fswl_top.WR_DISABLE_OP});
    sr_chk(8'h00);
    for (int i = 0; i < 6; i++) begin
      d = 8'($random(seed));
      i_fswl_host.xfer('{OP_WRITE_ENABLE_CMD});
      i_fswl_host.xfer('{OP_STATUS_WRITE_CMD, d});
      chk("quad enable", {7'h00, d[6]}, {7'h00, quad_en});
      // Reset pin only acts while the quad function is off
      @(posedge i_clk) i_hold_rst_n <= 1'b0;
      repeat (4) @(posedge i_clk);
      i_hold_rst_n <= 1'b1;
      repeat (4) @(posedge i_clk);
      chk("busy after pin", {7'h00, d[6]}, {7'h00, busy});
      sr_chk(exp_sr(d, d[6], d[6]));
      i_fswl_host.xfer('{OP_WRITE_ENABLE_CMD});
      wait_idle;
      sr_chk(exp_sr(d, ~d[6], 1'b0));
    end
    i_fswl_host.xfer('{OP_WRITE_ENABLE_CMD});
    i_fswl_host.xfer('{OP_STATUS_WRITE_CMD, 8'h80});
    wait_idle;
    @(posedge i_clk) i_wp_n <= 1'b0;
    i_fswl_host.xfer('{OP_WRITE_ENABLE_CMD});
    i_fswl_host.xfer('{OP_STATUS_WRITE_CMD, 8'h00});
    chk("refused count", 8'h02, n_ref);
    sr_chk(8'h82);
    @(posedge i_clk) i_wp_n <= 1'b1;
    i_fswl_host.xfer('{OP_STATUS_WRITE_CMD, 8'h04});
    wait_idle;
    sr_chk(8'h04);
    i_fswl_host.xfer('{OP_WRITE_ENABLE_CMD});
    i_fswl_host.xfer('{OP_CHIP_A});
    chk("refused count", 8'h03, n_ref);
    i_fswl_host.xfer('{OP_PROG, 8'hff, 8'h00, 8'h00, 8'ha5});
    chk("refused count", 8'h04, n_ref);
    i_fswl_host.xfer('{OP_PROG, 8'h00, 8'h00, 8'h00, 8'h5a});
    chk("busy program", 8'h01, {7'h00, busy});
    i_fswl_host.xfer('{OP_SUSPEND});
    chk("busy suspended", 8'h00, {7'h00, busy});
    i_fswl_host.xfer('{OP_RESUME});
    chk("busy resumed", 8'h01, {7'h00, busy});
    wait_idle;
    sr_chk(8'h04);
    give_verdict;
  end
endmodule
